// ---- dv/iaf_core_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module iaf_core_tb;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_acc_valid = 1'b0, i_acc_write = 1'b0, i_acc_full = 1'b0, i_acc_bank_a = 1'b0;
    logic [7:0] i_acc_file = 8'h00, i_acc_wdata = 8'h00, i_working_reg = 8'h00;
    logic [11:0] i_acc_full_addr = 12'h000, o_ram_addr;
    logic i_alu_valid = 1'b0;
    logic [2:0] i_alu_op = 3'h0;
    logic [7:0] i_alu_a = 8'h00, i_alu_b = 8'h00, i_alu_result = 8'h00;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00, o_ram_wdata, o_rd_data, o_alu_flags;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic o_ram_we, o_ram_re, o_rd_valid, o_rd_from_ram, o_pready, o_pslverr, err;
    logic nf = 1'b0;
    logic [7:0] nw = 8'h00, nr = 8'h00;
    int n_mismatch = 0;
    int tests_run = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    iaf_core u_iaf_core (.i_ref_clk, .i_rst_n, .i_acc_valid, .i_acc_write, .i_acc_full,
        .i_acc_bank_a, .i_acc_file, .i_acc_full_addr, .i_acc_wdata, .i_working_reg,
        .i_alu_valid, .i_alu_op, .i_alu_a, .i_alu_b, .i_alu_result, .o_ram_addr, .o_ram_we,
        .o_ram_re, .o_ram_wdata, .o_rd_valid, .o_rd_from_ram, .o_rd_data, .o_alu_flags,
        .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr);
    iaf_ram_model u_iaf_ram_model (.i_ref_clk, .i_ram_addr(o_ram_addr), .i_ram_we(o_ram_we),
        .i_ram_wdata(o_ram_wdata));
    // ----------------------------------------
    // Drivers and checks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge i_ref_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_ref_clk);
            k++;
        end while (o_pready !== 1'b1 && k < 20);
        if (o_pready !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    // One access, with an optional flag update in the same cycle; returns once outputs land.
    task automatic acc(input logic v, wr, ba, input logic [7:0] f, wd, input logic av,
            input logic [2:0] op, input logic [7:0] a, b);
        @(posedge i_ref_clk);
        i_acc_valid <= v;
        i_acc_write <= wr;
        i_acc_bank_a <= ba;
        i_acc_file <= f;
        i_acc_wdata <= wd;
        i_acc_full <= nf;
        i_working_reg <= nw;
        i_alu_result <= nr;
        i_alu_valid <= av;
        i_alu_op <= op;
        i_alu_a <= a;
        i_alu_b <= b;
        @(posedge i_ref_clk);
        i_acc_valid <= 1'b0;
        i_alu_valid <= 1'b0;
        #1;
    endtask : acc
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_modes;
        logic [7:0] fl [5] = '{8'hEA, 8'hEB, 8'hE9, 8'hEC, 8'hE8};
        logic [11:0] ea [5] = '{12'h0FF, 12'h101, 12'h101, 12'h0FE, 12'h100};
        logic [11:0] ep [5] = '{12'h100, 12'h101, 12'h100, 12'h100, 12'h100};
        apb(1'b1, 8'h00, 32'h0FF);
        nw = 8'hFE;
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, 1'b0, 1'b0, fl[i], 8'h00, 1'b0, 3'h0, 8'h00, 8'h00);
            chk({o_ram_re, o_rd_from_ram, 2'h0, o_ram_addr}, {4'hC, ea[i]});
            apb(1'b0, 8'h00, 32'h0);
            chk(rd, {20'h0, ep[i]});
        end
    endtask : sc_modes
    task automatic sc_ports;
        apb(1'b1, 8'h04, 32'hFFF);
        acc(1'b1, 1'b0, 1'b0, 8'hE2, 8'h00, 1'b0, 3'h0, 8'h00, 8'h00);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        chk(o_alu_flags, 8'h00);
        acc(1'b1, 1'b0, 1'b0, 8'hE1, 8'h00, 1'b0, 3'h0, 8'h00, 8'h00);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'hFFF);
        apb(1'b1, 8'h08, 32'hFE8);
        acc(1'b1, 1'b0, 1'b0, 8'hD8, 8'h00, 1'b0, 3'h0, 8'h00, 8'h00);
        chk({o_rd_valid, o_ram_re, o_rd_from_ram, o_rd_data, o_alu_flags}, 19'h40004);
        apb(1'b1, 8'h10, 32'h0);
        acc(1'b1, 1'b1, 1'b0, 8'hD8, 8'h33, 1'b1, iaf_pkg::ALU_ADD, 8'h7F, 8'h01);
        chk({o_ram_we, o_alu_flags}, 9'h000);
        acc(1'b1, 1'b1, 1'b0, 8'hEA, 8'h5A, 1'b0, 3'h0, 8'h00, 8'h00);
        chk({o_ram_we, o_ram_wdata, o_ram_addr}, {1'b1, 8'h5A, 12'h100});
        @(posedge i_ref_clk);
        #1;
        chk(u_iaf_ram_model.mem[12'h100], 8'h5A);
        apb(1'b1, 8'h00, 32'hFEE);
        acc(1'b1, 1'b1, 1'b0, 8'hEA, 8'h55, 1'b0, 3'h0, 8'h00, 8'h00);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'hF55);
    endtask : sc_ports
    task automatic sc_direct;
        apb(1'b1, 8'h0C, 32'hF3);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h3);
        acc(1'b1, 1'b0, 1'b1, 8'h45, 8'h00, 1'b0, 3'h0, 8'h00, 8'h00);
        chk(o_ram_addr, 12'h345);
        acc(1'b1, 1'b0, 1'b0, 8'h45, 8'h00, 1'b0, 3'h0, 8'h00, 8'h00);
        chk(o_ram_addr, 12'h045);
        acc(1'b1, 1'b0, 1'b0, 8'h90, 8'h00, 1'b0, 3'h0, 8'h00, 8'h00);
        chk(o_ram_addr, 12'hF90);
        acc(1'b1, 1'b0, 1'b0, 8'hC0, 8'h00, 1'b0, 3'h0, 8'h00, 8'h00);
        chk({o_rd_valid, o_rd_from_ram, o_ram_re, o_rd_data}, 11'h403);
        nf = 1'b1;
        @(posedge i_ref_clk);
        i_acc_full_addr <= 12'hABC;
        acc(1'b1, 1'b0, 1'b1, 8'h45, 8'h00, 1'b0, 3'h0, 8'h00, 8'h00);
        chk(o_ram_addr, 12'hABC);
        nf = 1'b0;
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'hABC);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask : sc_direct
    task automatic sc_flags;
        logic [2:0] op [8] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h3, 3'h4, 3'h5};
        logic [7:0] a [8] = '{8'h7F, 8'hFF, 8'h05, 8'h00, 8'h80, 8'h00, 8'h11, 8'h08};
        logic [7:0] b [8] = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
        logic [7:0] ex [8] = '{8'h1A, 8'h07, 8'h07, 8'h10, 8'h09, 8'h0D, 8'h1B, 8'h0A};
        nr = 8'h00;
        for (int i = 0; i < 8; i++) begin
            acc(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1, op[i], a[i], b[i]);
            chk(o_alu_flags, ex[i]);
        end
        nr = 8'h01;
        acc(1'b1, 1'b1, 1'b0, 8'hC8, 8'hFF, 1'b1, iaf_pkg::ALU_LOGIC, 8'h00, 8'h00);
        chk(o_alu_flags, 8'h0B);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0B);
    endtask : sc_flags
    task automatic tally_and_finish;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        sc_modes();
        sc_ports();
        sc_direct();
        sc_flags();
        tally_and_finish();
    end
endmodule : iaf_core_tb
`default_nettype wire

// ---- dv/iaf_ram_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module iaf_ram_model (
    // Clock
    input wire logic i_ref_clk,
    // Strobes from the block
    input wire logic [11:0] i_ram_addr,
    input wire logic i_ram_we,
    input wire logic [7:0] i_ram_wdata
);
    logic [7:0] mem [0:4095];
    // Only real RAM locations arrive here; register-file hits never strobe.
    always_ff @(posedge i_ref_clk) begin
        if (i_ram_we) begin
            mem[i_ram_addr] <= i_ram_wdata;
        end
    end
endmodule : iaf_ram_model
`default_nettype wire

// ---- hw/iaf_core.sv ----
// Notes on behaviour
// R1: Three 12-bit pointers, high and low byte each, reach all 4096 bytes.
// R2: Access to an indirect port goes to the address in its pointer.
// R3: Indirect read of any port location returns zero and sets zero flag.
// R4: Indirect write to a port location does nothing and keeps flags.
// R5: Plain port keeps pointer; post-down subtracts one; post-up adds one.
// R6: Pre-up port adds one first and accesses at the new value.
// R7: Indexed port uses pointer plus signed working reg; neither changes.
// R8: Pointer stepping never touches the arithmetic flags.
// R9: Pointer stepping works on all 12 bits with carry into high byte.
// R10: Write to a pointer byte beats that pointer's own step.
// R11: Access bit clear swaps bank select for the access bank mapping.
// R12: Full-address move uses its own 12-bit address, ignoring bank select.
// R13: Flag register write loses to flags the instruction computes.
// R14: Flags read zero in 7:5; N, OV, Z, DC, C in 4 down to 0.
// R15: Negative flag copies result bit 7.
// R16: Signed-wrap flag marks a wrong change of the sign bit.
// R17: Zero flag is set on a zero result, cleared otherwise.
// R18: Half carry is nibble carry, borrow inverted; rotates load bit 4 or 3.
// R19: Carry is carry out of bit 7, inverted borrow; rotates load bit 7 or 0.
// R20: Bank select gives address bits 11:8; upper bits read zero.
// R21: Access bank is bank 0 low half then bank 15 high half.
// R22: Pointer arithmetic and indexed addresses wrap modulo 4096.
`timescale 1ns/10ps
`default_nettype none
module iaf_core (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Operand access from the decoder
    input wire logic i_acc_valid,
    input wire logic i_acc_write,
    input wire logic i_acc_full,
    input wire logic i_acc_bank_a,
    input wire logic [7:0] i_acc_file,
    input wire logic [11:0] i_acc_full_addr,
    input wire logic [7:0] i_acc_wdata,
    input wire logic [7:0] i_working_reg,
    // ALU flag update
    input wire logic i_alu_valid,
    input wire logic [2:0] i_alu_op,
    input wire logic [7:0] i_alu_a,
    input wire logic [7:0] i_alu_b,
    input wire logic [7:0] i_alu_result,
    // Data RAM
    output logic [11:0] o_ram_addr,
    output logic o_ram_we,
    output logic o_ram_re,
    output logic [7:0] o_ram_wdata,
    // Read answer
    output logic o_rd_valid,
    output logic o_rd_from_ram,
    output logic [7:0] o_rd_data,
    output logic [7:0] o_alu_flags,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr
);
    // ------------------------------------------------------------
    // Address decode helpers
    // ------------------------------------------------------------
    function automatic logic [11:0] ptr_base(input logic [1:0] n);
        ptr_base = iaf_pkg::PTR_BASE_TOP - 12'(n) * iaf_pkg::PTR_STRIDE;
    endfunction : ptr_base

    // Returns the owning pointer of a slot address, or 3 for none.
    function automatic logic [1:0] ptr_of(input logic [11:0] addr);
        ptr_of = 2'h3;
        for (int n = 0; n < iaf_pkg::NUM_PTR; n++) begin
            if (addr[11:3] == 9'(ptr_base(2'(n)) >> 3) &&
                addr[2:0] <= iaf_pkg::OFS_PTR_LOW) begin
                ptr_of = 2'(n);
            end
        end
    endfunction : ptr_of

    function automatic logic is_port(input logic [11:0] addr);
        is_port = (ptr_of(addr) != 2'h3) && (addr[2:0] <= iaf_pkg::OFS_INDEXED);
    endfunction : is_port

    logic [11:0] ptr [iaf_pkg::NUM_PTR];
    logic [3:0] bank_select;
    logic [4:0] flags;
    logic [12:0] last_access;

    // ------------------------------------------------------------
    // Operand address generation
    // ------------------------------------------------------------
    logic [11:0] logical_addr, sel_ptr, eff_addr;
    logic [1:0] lg_ptr, lg_idx, eff_ptr;
    logic [2:0] lg_ofs;
    logic [7:0] int_rdata;
    logic lg_port, eff_is_port, eff_high, eff_low, eff_bank, eff_flags, eff_internal;
    logic forced_zero_rd, nop_wr, do_wr;
    always_comb begin
        if (i_acc_full) begin
            logical_addr = i_acc_full_addr; // see R12
        end else if (i_acc_bank_a) begin
            logical_addr = {bank_select, i_acc_file}; // see R20
        end else if (i_acc_file < iaf_pkg::ACCESS_SPLIT) begin
            logical_addr = {iaf_pkg::ACCESS_LOW_BANK, i_acc_file}; // see R11
        end else begin
            logical_addr = {iaf_pkg::ACCESS_HIGH_BANK, i_acc_file}; // see R21
        end
    end

    assign lg_ptr = ptr_of(logical_addr);
    assign lg_port = is_port(logical_addr);
    assign lg_ofs = logical_addr[2:0];
    assign lg_idx = lg_port ? lg_ptr : 2'h0;
    assign sel_ptr = ptr[lg_idx];
    always_comb begin
        eff_addr = logical_addr;
        if (lg_port) begin
            case (lg_ofs)
                iaf_pkg::OFS_PRE_UP: eff_addr = sel_ptr + 12'h001; // see R6
                iaf_pkg::OFS_INDEXED: begin
                    // Truncation to 12 bits gives the wrap. see R7, R22
                    eff_addr = sel_ptr + {{4{i_working_reg[7]}}, i_working_reg};
                end
                default: eff_addr = sel_ptr; // see R2
            endcase
        end
    end
    assign eff_is_port = lg_port && is_port(eff_addr);
    assign forced_zero_rd = i_acc_valid && !i_acc_write && eff_is_port; // see R3
    assign nop_wr = i_acc_valid && i_acc_write && eff_is_port; // see R4
    assign do_wr = i_acc_valid && i_acc_write && !eff_is_port;
    assign eff_ptr = ptr_of(eff_addr);
    assign eff_high = (eff_ptr != 2'h3) && (eff_addr[2:0] == iaf_pkg::OFS_PTR_HIGH);
    assign eff_low = (eff_ptr != 2'h3) && (eff_addr[2:0] == iaf_pkg::OFS_PTR_LOW);
    assign eff_bank = (eff_addr == iaf_pkg::BANK_SEL_ADDR);
    assign eff_flags = (eff_addr == iaf_pkg::FLAGS_ADDR);
    assign eff_internal = eff_high || eff_low || eff_bank || eff_flags;

    always_comb begin
        int_rdata = 8'h00;
        if (eff_high) begin
            int_rdata = {4'h0, ptr[eff_ptr][11:8]};
        end else if (eff_low) begin
            int_rdata = ptr[eff_ptr][7:0];
        end else if (eff_bank) begin
            int_rdata = {4'h0, bank_select};
        end else if (eff_flags) begin
            int_rdata = {3'h0, flags}; // see R14
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic apb_wr, apb_mapped;
    logic [31:0] apb_rd_value;
    assign apb_wr = i_psel && i_penable && i_pwrite && apb_mapped;
    assign apb_mapped = (i_paddr <= iaf_pkg::APB_LAST) && (i_paddr[1:0] == 2'h0);
    assign o_pready = i_psel && i_penable;
    assign o_pslverr = i_psel && i_penable && !apb_mapped;
    always_comb begin
        case (i_paddr)
            iaf_pkg::APB_PTR0: apb_rd_value = {20'h00000, ptr[0]};
            iaf_pkg::APB_PTR1: apb_rd_value = {20'h00000, ptr[1]};
            iaf_pkg::APB_PTR2: apb_rd_value = {20'h00000, ptr[2]};
            iaf_pkg::APB_BANK: apb_rd_value = {28'h0000000, bank_select};
            iaf_pkg::APB_FLAGS: apb_rd_value = {27'h0000000, flags};
            iaf_pkg::APB_LAST: apb_rd_value = {19'h00000, last_access};
            default: apb_rd_value = 32'h00000000;
        endcase
    end

    // Read data is latched in the setup cycle, so the access phase needs no wait.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h00000000;
        end else if (i_psel && !i_penable) begin
            o_prdata <= apb_rd_value;
        end
    end

    // ------------------------------------------------------------
    // Pointers
    // ------------------------------------------------------------
    logic [11:0] next_ptr [iaf_pkg::NUM_PTR];
    always_comb begin
        for (int n = 0; n < iaf_pkg::NUM_PTR; n++) begin
            next_ptr[n] = ptr[n];
            if (apb_wr && i_paddr == iaf_pkg::APB_PTR0 + 8'(4 * n)) begin
                next_ptr[n] = i_pwdata[11:0];
            end
            // A port write that turns into a no-operation leaves the pointer alone.
            if (i_acc_valid && lg_port && lg_ptr == 2'(n) && !nop_wr) begin
                case (lg_ofs)
                    iaf_pkg::OFS_POST_DOWN: next_ptr[n] = ptr[n] - 12'h001; // see R5, R9
                    iaf_pkg::OFS_POST_UP: next_ptr[n] = ptr[n] + 12'h001; // see R5, R22
                    iaf_pkg::OFS_PRE_UP: next_ptr[n] = ptr[n] + 12'h001; // see R6
                    default: next_ptr[n] = next_ptr[n];
                endcase
            end
            if (do_wr && eff_ptr == 2'(n) && eff_high) begin
                next_ptr[n][11:8] = i_acc_wdata[3:0]; // see R10
            end
            if (do_wr && eff_ptr == 2'(n) && eff_low) begin
                next_ptr[n][7:0] = i_acc_wdata; // see R10
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int n = 0; n < iaf_pkg::NUM_PTR; n++) begin
                ptr[n] <= iaf_pkg::PTR_RESET;
            end
        end else begin
            for (int n = 0; n < iaf_pkg::NUM_PTR; n++) begin
                ptr[n] <= next_ptr[n]; // see R1
            end
        end
    end

    // ------------------------------------------------------------
    // Bank select
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bank_select <= iaf_pkg::BANK_RESET;
        end else if (do_wr && eff_bank) begin
            bank_select <= i_acc_wdata[3:0]; // see R20
        end else if (apb_wr && i_paddr == iaf_pkg::APB_BANK) begin
            bank_select <= i_pwdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // ALU flags
    // ------------------------------------------------------------
    // Returns {update mask, computed flags}.
    function automatic logic [9:0] alu_flags_of(input iaf_pkg::iaf_alu_op_t op,
            input logic [7:0] a, input logic [7:0] b, input logic [7:0] res_in,
            input logic c_in);
        logic [8:0] sum;
        logic [4:0] nib, mask, f;
        logic [7:0] bb, res;
        sum = 9'h000;
        nib = 5'h00;
        bb = b;
        res = res_in;
        mask = 5'h00;
        f = 5'h00;
        case (op)
            iaf_pkg::ALU_ADD, iaf_pkg::ALU_SUB: begin
                // Subtraction adds the two's complement, so carries mean no borrow.
                bb = (op == iaf_pkg::ALU_SUB) ? ~b : b;
                sum = {1'b0, a} + {1'b0, bb} + 9'(op == iaf_pkg::ALU_SUB);
                nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(op == iaf_pkg::ALU_SUB);
                res = sum[7:0];
                mask = 5'h1F;
                f[iaf_pkg::FLAG_C] = sum[8]; // see R19
                f[iaf_pkg::FLAG_DC] = nib[4]; // see R18
                f[iaf_pkg::FLAG_OV] = (a[7] == bb[7]) && (res[7] != a[7]); // see R16
            end
            iaf_pkg::ALU_LOGIC: mask = 5'h14;
            iaf_pkg::ALU_ROT_RIGHT: begin
                res = {c_in, a[7:1]};
                mask = 5'h17;
                f[iaf_pkg::FLAG_C] = a[0]; // see R19
                f[iaf_pkg::FLAG_DC] = a[4]; // see R18
            end
            iaf_pkg::ALU_ROT_LEFT: begin
                res = {a[6:0], c_in};
                mask = 5'h17;
                f[iaf_pkg::FLAG_C] = a[7]; // see R19
                f[iaf_pkg::FLAG_DC] = a[3]; // see R18
            end
            default: mask = 5'h00;
        endcase
        f[iaf_pkg::FLAG_N] = res[7]; // see R15
        f[iaf_pkg::FLAG_Z] = (res == 8'h00); // see R17
        alu_flags_of = {mask, f};
    endfunction : alu_flags_of

    logic [9:0] alu_out;
    logic [4:0] upd_mask, next_flags;
    assign alu_out = alu_flags_of(iaf_pkg::iaf_alu_op_t'(i_alu_op), i_alu_a, i_alu_b,
        i_alu_result, flags[iaf_pkg::FLAG_C]);
    // Pointer stepping has no path into the flags at all. see R8
    assign upd_mask = (i_alu_valid && !nop_wr) ? alu_out[9:5] : 5'h00; // see R4
    always_comb begin
        next_flags = flags;
        if (apb_wr && i_paddr == iaf_pkg::APB_FLAGS) begin
            next_flags = i_pwdata[4:0];
        end
        if (do_wr && eff_flags) begin
            next_flags = i_acc_wdata[4:0];
        end
        next_flags = (next_flags & ~upd_mask) | (alu_out[4:0] & upd_mask); // see R13
        if (forced_zero_rd) begin
            next_flags[iaf_pkg::FLAG_Z] = 1'b1; // see R3
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flags <= iaf_pkg::FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    assign o_alu_flags = {3'h0, flags}; // see R14

    // ------------------------------------------------------------
    // RAM request and read answer
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ram_addr <= 12'h000;
            o_ram_we <= 1'b0;
            o_ram_re <= 1'b0;
            o_ram_wdata <= 8'h00;
            o_rd_valid <= 1'b0;
            o_rd_from_ram <= 1'b0;
            o_rd_data <= 8'h00;
            last_access <= 13'h0000;
        end else begin
            o_ram_addr <= eff_addr;
            o_ram_wdata <= i_acc_wdata;
            o_ram_we <= do_wr && !eff_internal; // see R4
            o_ram_re <= i_acc_valid && !i_acc_write && !eff_is_port && !eff_internal;
            o_rd_valid <= i_acc_valid && !i_acc_write;
            o_rd_from_ram <= i_acc_valid && !i_acc_write && !eff_is_port && !eff_internal;
            o_rd_data <= forced_zero_rd ? 8'h00 : int_rdata; // see R3
            if (i_acc_valid) begin
                last_access <= {eff_is_port, eff_addr};
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    zero_read_a: assert property ( // see R3
        forced_zero_rd |=> o_rd_valid && !o_rd_from_ram && o_rd_data == 8'h00
            && flags[iaf_pkg::FLAG_Z])
        else $error("port read through pointer did not give zero");
    port_write_nop_a: assert property ( // see R4
        nop_wr && !(apb_wr && i_paddr == iaf_pkg::APB_FLAGS) |=> !o_ram_we && $stable(flags))
        else $error("port write through pointer was not a no-operation");
    post_up_step_a: assert property ( // see R5
        i_acc_valid && lg_port && lg_ofs == iaf_pkg::OFS_POST_UP && !nop_wr && !apb_wr
            && !(do_wr && (eff_high || eff_low))
            |=> ptr[$past(lg_idx)] == $past(sel_ptr) + 12'h001 && o_ram_addr == $past(sel_ptr))
        else $error("post-up port stepped wrongly");
    post_down_step_a: assert property ( // see R9
        i_acc_valid && lg_port && lg_ofs == iaf_pkg::OFS_POST_DOWN && !nop_wr && !apb_wr
            && !(do_wr && (eff_high || eff_low))
            |=> ptr[$past(lg_idx)] == $past(sel_ptr) - 12'h001)
        else $error("post-down port stepped wrongly");
    pre_up_addr_a: assert property ( // see R6
        i_acc_valid && lg_port && lg_ofs == iaf_pkg::OFS_PRE_UP && !eff_is_port
            |=> o_ram_addr == $past(sel_ptr) + 12'h001)
        else $error("pre-up port used the old pointer");
    indexed_addr_a: assert property ( // see R7
        i_acc_valid && lg_port && lg_ofs == iaf_pkg::OFS_INDEXED && !apb_wr
            && !(do_wr && (eff_high || eff_low))
            |=> o_ram_addr == $past(sel_ptr) + {{4{$past(i_working_reg[7])}},
                $past(i_working_reg)} && ptr[$past(lg_idx)] == $past(sel_ptr))
        else $error("indexed port address or pointer wrong");
    access_bank_a: assert property ( // see R21
        i_acc_valid && !i_acc_full && !i_acc_bank_a && !lg_port
            |=> o_ram_addr[11:8] == ($past(i_acc_file[7]) ? 4'hF : 4'h0))
        else $error("access bank mapping wrong");
    bank_direct_a: assert property ( // see R11
        i_acc_valid && !i_acc_full && i_acc_bank_a && !lg_port
            |=> o_ram_addr[11:8] == $past(bank_select))
        else $error("bank select not used in direct addressing");
    flags_guard_a: assert property ( // see R13
        do_wr && eff_flags && i_alu_valid && i_alu_op == 3'b011
            |=> flags[iaf_pkg::FLAG_C] == $past(i_acc_wdata[0])
            && flags[iaf_pkg::FLAG_Z] == ($past(i_alu_result) == 8'h00))
        else $error("flag register write beat computed flags");
    ptr_write_wins_a: assert property ( // see R10
        do_wr && eff_low && lg_port && eff_ptr == lg_ptr |=> ptr[$past(eff_ptr)][7:0]
            == $past(i_acc_wdata))
        else $error("pointer byte write lost to step");
    flags_upper_a: assert property ( // see R14
        !i_alu_valid && !i_acc_valid && !apb_wr
            |=> $stable(o_alu_flags) && o_alu_flags[7:5] == 3'h0)
        else $error("flag register changed while idle or upper bits not zero");

endmodule : iaf_core
`default_nettype wire

// ---- hw/iaf_pkg.sv ----
package iaf_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NUM_PTR = 3;
    localparam int FLAG_W = 5;
    // Pointer n owns an 8-byte slot at PTR_BASE_TOP - n * PTR_STRIDE.
    localparam logic [11:0] PTR_BASE_TOP = 12'hFE8;
    localparam logic [11:0] PTR_STRIDE = 12'h008;
    localparam logic [2:0] OFS_PLAIN = 3'h0;
    localparam logic [2:0] OFS_POST_DOWN = 3'h1;
    localparam logic [2:0] OFS_POST_UP = 3'h2;
    localparam logic [2:0] OFS_PRE_UP = 3'h3;
    localparam logic [2:0] OFS_INDEXED = 3'h4;
    localparam logic [2:0] OFS_PTR_HIGH = 3'h5;
    localparam logic [2:0] OFS_PTR_LOW = 3'h6;
    localparam logic [11:0] BANK_SEL_ADDR = 12'hFC0;
    localparam logic [11:0] FLAGS_ADDR = 12'hFC8;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam int FLAG_N = 4;
    localparam int FLAG_OV = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_DC = 1;
    localparam int FLAG_C = 0;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam logic [11:0] PTR_RESET = 12'h000;
    localparam logic [7:0] APB_PTR0 = 8'h00;
    localparam logic [7:0] APB_PTR1 = 8'h04;
    localparam logic [7:0] APB_PTR2 = 8'h08;
    localparam logic [7:0] APB_BANK = 8'h0C;
    localparam logic [7:0] APB_FLAGS = 8'h10;
    localparam logic [7:0] APB_LAST = 8'h14;
    typedef enum logic [2:0] {
        ALU_NONE = 3'b000,
        ALU_ADD = 3'b001,
        ALU_SUB = 3'b010,
        ALU_LOGIC = 3'b011,
        ALU_ROT_RIGHT = 3'b100,
        ALU_ROT_LEFT = 3'b101
    } iaf_alu_op_t;
endpackage : iaf_pkg
